// [hw/gpio_pkg.sv]
// Contract
// - Port reads return live pin levels, never the output latches.
// - Reset sets every direction bit of both ports to one.
// - Ports are six bits wide; bits 7 and 6 read as zero.
// - Port B bit 3 is input only; its driver never enables.
// - Pins given to alternate functions read as zero.
// - Pull-ups and wake exist on B bits 0,1,3,4, enabled separately.
// - Bit 3 as external reset input: no pull-up, no wake.
// - Direction one floats the pin; zero drives the output latch.
// - Direction registers load only by direction-load, never read back.
// - Output latches hold until rewritten; inputs are not latched.
// - Config bit 7 low enables wake on change, high disables.
// - Config bit 6 low enables weak pull-ups, high disables.
// - Config bit 5 high makes C bit 5 the timer clock input.
// - Bit set/clear reads pins, changes one bit, writes whole port.
// - Status bit 7 is one after wake reset, zero otherwise; a status write also loads it.
// - Output pins get no pull-up and no wake whatever the config.
// - Writes land at cycle end; reads sample pins at cycle start.
package gpio_pkg;

    // ==========================================
    // Addresses and fields
    localparam logic [2:0] ADDR_STATUS = 3'h3;
    localparam logic [2:0] ADDR_PORT_B_DATA = 3'h6;
    localparam logic [2:0] ADDR_PORT_C_DATA = 3'h7;
    localparam int CFG_WAKE_BIT = 7;
    localparam int CFG_PULLUP_BIT = 6;
    localparam int CFG_TIMER_BIT = 5;
    localparam int STATUS_WAKE_BIT = 7;
    localparam int TIMER_PIN_BIT = 5;

    // ==========================================
    // Reset values and masks
    localparam logic [7:0] CFG_RESET = 8'hff;
    localparam logic [5:0] DIR_RESET = 6'h3f;
    localparam logic [5:0] WAKE_ELIGIBLE = 6'h1b;
    localparam logic [5:0] INPUT_ONLY_B = 6'h08;
    localparam logic [5:0] TIMER_PIN_C = 6'h20;

    // ==========================================
    // Core operations and instruction phases
    typedef enum logic [6:0] {
        OP_NONE = 7'h01,
        OP_READ = 7'h02,
        OP_WRITE = 7'h04,
        OP_BIT_SET = 7'h08,
        OP_BIT_CLEAR = 7'h10,
        OP_DIR_LOAD = 7'h20,
        OP_CFG_LOAD = 7'h40
    } op_e;

    typedef enum logic [3:0] {
        PH_Q1 = 4'h1,
        PH_Q2 = 4'h2,
        PH_Q3 = 4'h4,
        PH_Q4 = 4'h8
    } phase_e;

    typedef struct packed {
        op_e op;
        logic [2:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] data;
    } core_req_s;

    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } pin_drive_s;

endpackage

// [hw/dual_port_gpio_with_wake.sv]
`timescale 1ns/10ps
`default_nettype none

module dual_port_gpio_with_wake (
    input wire logic clock,
    input wire logic sys_rst,
    input wire gpio_pkg::core_req_s req,
    input wire logic reset_by_wake,
    input wire logic sleep,
    input wire logic [5:0] alt_mask_b,
    input wire logic [5:0] alt_mask_c,
    input wire logic [5:0] pin_in_b,
    input wire logic [5:0] pin_in_c,
    output gpio_pkg::pin_drive_s drive_b,
    output gpio_pkg::pin_drive_s drive_c,
    output logic [5:0] weak_pullup_b,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic cycle_start,
    output logic wake_reset,
    output logic timer_clock_source_select,
    output logic timer_external_clock_pin
);

    // ==========================================
    // Instruction phase divider
    gpio_pkg::phase_e phase;
    gpio_pkg::phase_e next_phase;

    always_comb begin
        case (phase)
            gpio_pkg::PH_Q1: next_phase = gpio_pkg::PH_Q2;
            gpio_pkg::PH_Q2: next_phase = gpio_pkg::PH_Q3;
            gpio_pkg::PH_Q3: next_phase = gpio_pkg::PH_Q4;
            gpio_pkg::PH_Q4: next_phase = gpio_pkg::PH_Q1;
            default: next_phase = gpio_pkg::PH_Q1;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            phase <= gpio_pkg::PH_Q1;
        end else begin
            phase <= next_phase;
        end
    end

    wire at_q1 = (phase == gpio_pkg::PH_Q1);
    wire at_q2 = (phase == gpio_pkg::PH_Q2);
    wire at_q4 = (phase == gpio_pkg::PH_Q4);

    // ==========================================
    // Register state
    gpio_pkg::core_req_s cur;
    logic [5:0] latch_b;
    logic [5:0] latch_c;
    logic [5:0] port_b_direction;
    logic [5:0] port_c_direction;
    logic [7:0] pin_and_timer_config;
    logic [5:0] snap_b;
    logic [5:0] snap_c;
    logic [5:0] last_read_b;
    logic wake_reset_flag;

    // ==========================================
    // Decode
    wire is_b = (cur.addr == gpio_pkg::ADDR_PORT_B_DATA);
    wire is_c = (cur.addr == gpio_pkg::ADDR_PORT_C_DATA);
    wire is_status = (cur.addr == gpio_pkg::ADDR_STATUS);
    wire op_rd = (cur.op == gpio_pkg::OP_READ);
    wire op_wr = (cur.op == gpio_pkg::OP_WRITE);
    wire op_set = (cur.op == gpio_pkg::OP_BIT_SET);
    wire op_clr = (cur.op == gpio_pkg::OP_BIT_CLEAR);
    wire op_rmw = op_set || op_clr;
    wire req_reads = (req.op == gpio_pkg::OP_READ) ||
        (req.op == gpio_pkg::OP_BIT_SET) ||
        (req.op == gpio_pkg::OP_BIT_CLEAR);
    wire req_is_b = (req.addr == gpio_pkg::ADDR_PORT_B_DATA);

    // Alternate-function pins read as zero
    wire [5:0] live_b = pin_in_b & ~alt_mask_b;
    wire [5:0] live_c = pin_in_c & ~alt_mask_c;

    wire [5:0] snap_sel = is_b ? snap_b : snap_c;
    wire [7:0] status_view =
        {wake_reset_flag, 7'h00};
    wire [7:0] read_value = is_status ? status_view :
        {2'h0, snap_sel};

    // Bit set/clear rewrites every pin level, not the old latch
    wire [5:0] bit_mask = 6'(6'h01 << cur.bit_sel);
    wire [5:0] rmw_value = op_set ? (snap_sel | bit_mask) :
        (snap_sel & ~bit_mask);
    wire [5:0] write_value = op_rmw ? rmw_value : cur.data[5:0];
    wire port_write = (op_wr || op_rmw) && at_q4;

    wire dir_write = (cur.op == gpio_pkg::OP_DIR_LOAD) && at_q4;
    wire cfg_write = (cur.op == gpio_pkg::OP_CFG_LOAD) && at_q4;

    // ==========================================
    // Request capture and pin sampling at cycle start
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cur <= '{op: gpio_pkg::OP_NONE, default: '0};
            snap_b <= 6'h00;
            snap_c <= 6'h00;
        end else if (at_q1) begin
            cur <= req;
            snap_b <= live_b;
            snap_c <= live_c;
        end
    end

    // Last value seen by software on port B, reference for wake
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            last_read_b <= 6'h00;
        end else if (at_q1 && req_reads && req_is_b) begin
            last_read_b <= live_b;
        end
    end

    // ==========================================
    // Read answer, one pulse per read-type instruction
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= at_q2 && (op_rd || op_rmw);
            if (at_q2 && (op_rd || op_rmw)) begin
                rdata <= read_value;
            end
        end
    end

    // ==========================================
    // Output latches: cleared to zero by reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            latch_b <= 6'h00;
            latch_c <= 6'h00;
        end else if (port_write && is_b) begin
            latch_b <= write_value;
        end else if (port_write && is_c) begin
            latch_c <= write_value;
        end
    end

    // ==========================================
    // Direction and configuration: write-only
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            port_b_direction <= gpio_pkg::DIR_RESET;
            port_c_direction <= gpio_pkg::DIR_RESET;
            pin_and_timer_config <= gpio_pkg::CFG_RESET;
        end else begin
            if (dir_write && is_b) begin
                port_b_direction <= cur.data[5:0];
            end
            if (dir_write && is_c) begin
                port_c_direction <= cur.data[5:0];
            end
            if (cfg_write) begin
                pin_and_timer_config <= cur.data;
            end
        end
    end

    // Status bit 7 is caught from the reset cause during reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wake_reset_flag <= reset_by_wake;
        end else if (op_wr && is_status && at_q4) begin
            wake_reset_flag <= cur.data[gpio_pkg::STATUS_WAKE_BIT];
        end
    end

    // ==========================================
    // Pin drivers, pull-ups and wake
    wire timer_sel = pin_and_timer_config[gpio_pkg::CFG_TIMER_BIT];
    wire pullup_on = ~pin_and_timer_config[gpio_pkg::CFG_PULLUP_BIT];
    wire wake_on = ~pin_and_timer_config[gpio_pkg::CFG_WAKE_BIT];

    // Bit 3 as external reset drops out of both shared functions
    wire [5:0] ext_reset_pin = alt_mask_b & gpio_pkg::INPUT_ONLY_B;
    wire [5:0] eligible_b = gpio_pkg::WAKE_ELIGIBLE &
        port_b_direction & ~ext_reset_pin;

    wire [5:0] next_oe_b = ~port_b_direction &
        ~gpio_pkg::INPUT_ONLY_B;
    wire [5:0] next_oe_c = ~port_c_direction &
        ~(timer_sel ? gpio_pkg::TIMER_PIN_C : 6'h00);
    wire [5:0] next_pullup = pullup_on ? eligible_b : 6'h00;
    wire [5:0] changed_b = (pin_in_b ^ last_read_b) & eligible_b;
    wire next_wake = sleep && wake_on && (|changed_b);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            drive_b <= '0;
            drive_c <= '0;
            weak_pullup_b <= 6'h00;
            wake_reset <= 1'b0;
            timer_clock_source_select <= 1'b1;
            timer_external_clock_pin <= 1'b0;
            cycle_start <= 1'b0;
        end else begin
            drive_b <= '{out: latch_b, oe: next_oe_b};
            drive_c <= '{out: latch_c, oe: next_oe_c};
            weak_pullup_b <= next_pullup;
            // Held until the reset it asks for arrives
            wake_reset <= wake_reset || next_wake;
            timer_clock_source_select <= timer_sel;
            timer_external_clock_pin <=
                pin_in_c[gpio_pkg::TIMER_PIN_BIT];
            cycle_start <= at_q1;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    logic past_rst;
    always_ff @(posedge clock) begin
        past_rst <= sys_rst;
    end

    reset_dir_a: assert property (past_rst |->
        port_b_direction == gpio_pkg::DIR_RESET &&
        port_c_direction == gpio_pkg::DIR_RESET)
        else $error("direction not all ones after reset");

    cfg_reset_a: assert property (past_rst |->
        pin_and_timer_config == gpio_pkg::CFG_RESET)
        else $error("config not all ones after reset");

    input_only_a: assert property (!past_rst |->
        !drive_b.oe[3])
        else $error("input-only pin driven");

    drive_map_a: assert property (!past_rst |->
        drive_b.oe == ($past(~port_b_direction) & 6'h37) &&
        drive_c.out == $past(latch_c))
        else $error("driver does not follow direction");

    timer_pin_a: assert property (
        $past(timer_sel) && !past_rst |-> !drive_c.oe[5])
        else $error("timer clock pin driven");

    read_pins_a: assert property (
        at_q1 && req.op == gpio_pkg::OP_READ && req_is_b |->
        ##2 rvalid && rdata == {2'h0, $past(live_b, 2)})
        else $error("read does not return pin levels");

    high_zero_a: assert property (rvalid |->
        rdata[6] == 1'b0 && (is_status || !rdata[7]))
        else $error("unimplemented bits read nonzero");

    pullup_gate_a: assert property (!past_rst |->
        (weak_pullup_b & ~$past(eligible_b)) == 6'h00 &&
        !(($past(alt_mask_b[3])) && weak_pullup_b[3]))
        else $error("pull-up on a pin that may not have one");

    latch_hold_a: assert property (
        !at_q4 |=> $stable(latch_b) && $stable(latch_c))
        else $error("latch changed outside write phase");

    rmw_write_a: assert property (
        at_q4 && op_set && is_b |=>
        latch_b == ($past(snap_b) | $past(bit_mask)))
        else $error("bit set did not rewrite pin levels");

    wake_cause_a: assert property (
        $rose(wake_reset) |-> $past(sleep) &&
        !$past(pin_and_timer_config[7]))
        else $error("wake reset without sleep and enable");

    status_flag_a: assert property (past_rst |->
        wake_reset_flag == $past(reset_by_wake))
        else $error("status wake flag wrong after reset");

    cycle_mark_a: assert property (cycle_start == at_q2)
        else $error("cycle start mark out of phase");

    timer_copy_a: assert property (!past_rst |->
        timer_external_clock_pin == $past(pin_in_c[5]))
        else $error("timer clock pin copy wrong");

    wake_hold_a: assert property (wake_reset |=> wake_reset)
        else $error("wake request dropped before reset");

    status_write_c: cover property (op_wr && is_status && at_q4);

    rmw_seen_c: cover property (
        at_q4 && op_clr && is_c ##1 !at_q4);
    wake_seen_c: cover property ($rose(wake_reset));
    dir_seen_c: cover property (dir_write && is_b ##1
        drive_b.oe != 6'h00);

endmodule

`default_nettype wire

// [dv/gpio_pins_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// External circuitry on both ports
module gpio_pins_model (
    input wire logic clock,
    input wire gpio_pkg::pin_drive_s drive_b,
    input wire gpio_pkg::pin_drive_s drive_c,
    input wire logic [5:0] weak_pullup_b,
    input wire logic [5:0] ext_b,
    input wire logic [5:0] ext_c,
    input wire logic [5:0] ext_en,
    output logic [5:0] pin_in_b,
    output logic [5:0] pin_in_c
);
    // Released lines wander unless pulled up, so a stale level never passes as valid
    logic [5:0] wander = 6'h15;
    logic [5:0] idle_b;
    always @(posedge clock) begin
        wander <= ~wander;
    end
    assign idle_b = weak_pullup_b | wander;
    // Driver wins; otherwise the external level where enabled, else the idle level
    assign pin_in_b = (drive_b.oe & drive_b.out)
        | (~drive_b.oe & ext_en & ext_b) | (~drive_b.oe & ~ext_en & idle_b);
    assign pin_in_c = (drive_c.oe & drive_c.out)
        | (~drive_c.oe & ext_en & ext_c) | (~drive_c.oe & ~ext_en & wander);
endmodule

`default_nettype wire

// [dv/dual_port_gpio_with_wake_test.sv]
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH %0t got %h want %h", $time, (a), (e)); end end

module dual_port_gpio_with_wake_test;
    localparam gpio_pkg::op_e rd_op = gpio_pkg::OP_READ;
    localparam gpio_pkg::op_e wr_op = gpio_pkg::OP_WRITE;
    localparam gpio_pkg::op_e bs_op = gpio_pkg::OP_BIT_SET;
    localparam gpio_pkg::op_e bc_op = gpio_pkg::OP_BIT_CLEAR;
    localparam gpio_pkg::op_e dir_op = gpio_pkg::OP_DIR_LOAD;
    localparam gpio_pkg::op_e cfg_op = gpio_pkg::OP_CFG_LOAD;
    localparam gpio_pkg::core_req_s idle_req = '{gpio_pkg::OP_NONE, 3'h0,
        3'h0, 8'h00};
    typedef struct packed {
        gpio_pkg::core_req_s req;
        logic [5:0] ext_b;
        logic [5:0] ext_c;
        logic [8:0] rd;
        gpio_pkg::pin_drive_s db;
        gpio_pkg::pin_drive_s dc;
        logic [5:0] pu;
    } row_s;
    // Drive columns show the state entering each row: writes land later
    row_s rows [13] = '{
    '{'{rd_op,3'h6,3'h0,8'h00},6'h2a,6'h00,9'h12a,12'h000,12'h000,6'h00},
    '{'{rd_op,3'h7,3'h0,8'h00},6'h2a,6'h15,9'h115,12'h000,12'h000,6'h00},
    '{'{wr_op,3'h6,3'h0,8'hff},6'h00,6'h00,9'h000,12'h000,12'h000,6'h00},
    '{'{dir_op,3'h6,3'h0,8'h00},6'h00,6'h00,9'h000,12'hfc0,12'h000,6'h00},
    '{'{dir_op,3'h7,3'h0,8'h00},6'h00,6'h00,9'h000,12'hff7,12'h000,6'h00},
    '{'{rd_op,3'h6,3'h0,8'h00},6'h00,6'h00,9'h137,12'hff7,12'h01f,6'h00},
    '{'{bc_op,3'h6,3'h0,8'h00},6'h00,6'h00,9'h137,12'hff7,12'h01f,6'h00},
    '{'{wr_op,3'h7,3'h0,8'hc5},6'h00,6'h00,9'h000,12'hdb7,12'h01f,6'h00},
    '{'{cfg_op,3'h0,3'h0,8'h00},6'h00,6'h00,9'h000,12'hdb7,12'h15f,6'h00},
    '{'{dir_op,3'h6,3'h0,8'h3f},6'h00,6'h00,9'h000,12'hdb7,12'h17f,6'h00},
    '{'{rd_op,3'h7,3'h0,8'h00},6'h00,6'h00,9'h105,12'hd80,12'h17f,6'h1b},
    '{'{rd_op,3'h6,3'h0,8'h00},6'h2d,6'h00,9'h12d,12'hd80,12'h17f,6'h1b},
    '{'{bs_op,3'h6,3'h1,8'h00},6'h2d,6'h00,9'h12d,12'hd80,12'h17f,6'h1b}};
    logic clock;
    logic sys_rst;
    logic reset_by_wake;
    logic sleep;
    logic [5:0] alt_mask_b;
    logic [5:0] alt_mask_c;
    logic [5:0] ext_b;
    logic [5:0] ext_c;
    logic [5:0] ext_en;
    logic [5:0] pin_in_b;
    logic [5:0] pin_in_c;
    logic [5:0] weak_pullup_b;
    logic [7:0] rdata;
    logic rvalid;
    logic wake_reset;
    logic timer_clock_source_select;
    logic cycle_start;
    logic timer_external_clock_pin;
    gpio_pkg::core_req_s req;
    gpio_pkg::pin_drive_s drive_b;
    gpio_pkg::pin_drive_s drive_c;
    int checks = 0;
    int error_cnt = 0;
    int cyc = 0;

    dual_port_gpio_with_wake DUT (.clock(clock), .sys_rst(sys_rst),
        .req(req), .reset_by_wake(reset_by_wake), .sleep(sleep),
        .alt_mask_b(alt_mask_b), .alt_mask_c(alt_mask_c),
        .pin_in_b(pin_in_b), .pin_in_c(pin_in_c), .drive_b(drive_b),
        .drive_c(drive_c), .weak_pullup_b(weak_pullup_b), .rdata(rdata),
        .rvalid(rvalid), .cycle_start(cycle_start), .wake_reset(wake_reset),
        .timer_clock_source_select(timer_clock_source_select),
        .timer_external_clock_pin(timer_external_clock_pin));
    gpio_pins_model pins (.clock(clock), .drive_b(drive_b),
        .drive_c(drive_c), .weak_pullup_b(weak_pullup_b), .ext_b(ext_b),
        .ext_c(ext_c), .ext_en(ext_en), .pin_in_b(pin_in_b),
        .pin_in_c(pin_in_c));

    // ==========================================
    // Clock, timeout and verdict
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 1000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Bus tasks: each op spans one whole instruction cycle
    task automatic do_reset(input logic w);
        sys_rst = 1'b1;
        reset_by_wake = w;
        sleep = 1'b0;
        repeat (10) @(posedge clock);
        #1 sys_rst = 1'b0;
    endtask
    task automatic do_op(input gpio_pkg::core_req_s r, input logic [8:0] rd);
        req = r;
        @(posedge clock);
        #1 req = idle_req;
        `CHK(cycle_start, 1'b1)
        // Read answer stands only between the Q2 and Q3 edges
        @(posedge clock);
        #1;
        if (rd[8]) begin
            `CHK(rvalid, 1'b1)
            `CHK(rdata, rd[7:0])
        end
        repeat (2) @(posedge clock);
        #1;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        clock = 1'b0;
        req = idle_req;
        alt_mask_b = 6'h00;
        alt_mask_c = 6'h00;
        ext_b = 6'h00;
        ext_c = 6'h00;
        ext_en = 6'h3f;
        do_reset(1'b0);
        `CHK({drive_b.oe, drive_c.oe}, 12'h000)
        `CHK(timer_clock_source_select, 1'b1)
        foreach (rows[i]) begin
            ext_b = rows[i].ext_b;
            ext_c = rows[i].ext_c;
            do_op(rows[i].req, rows[i].rd);
            `CHK(drive_b, rows[i].db)
            `CHK(drive_c, rows[i].dc)
            `CHK(weak_pullup_b, rows[i].pu)
        end
        @(posedge clock);
        #1;
        `CHK(drive_b.out, 6'h2f)
        // Sleep: a non-eligible pin must not wake, an eligible one must
        sleep = 1'b1;
        ext_b = 6'h29;
        repeat (4) @(posedge clock);
        #1;
        `CHK(wake_reset, 1'b0)
        ext_b = 6'h3d;
        repeat (2) @(posedge clock);
        #1;
        `CHK(wake_reset, 1'b1)
        do_reset(1'b1);
        do_op('{rd_op, 3'h3, 3'h0, 8'h00}, 9'h180);
        do_reset(1'b0);
        do_op('{rd_op, 3'h3, 3'h0, 8'h00}, 9'h100);
        alt_mask_b = 6'h08;
        ext_b = 6'h3f;
        do_op('{cfg_op, 3'h0, 3'h0, 8'h00}, 9'h000);
        do_op('{rd_op, 3'h6, 3'h0, 8'h00}, 9'h137);
        `CHK(weak_pullup_b, 6'h13)
        `CHK(timer_clock_source_select, 1'b0)
        // Port C alternate pin reads zero; the timer pin copy is unmasked
        alt_mask_c = 6'h01;
        ext_c = 6'h21;
        do_op('{rd_op, 3'h7, 3'h0, 8'h00}, 9'h120);
        `CHK(timer_external_clock_pin, 1'b1)
        do_op('{wr_op, 3'h3, 3'h0, 8'h80}, 9'h000);
        do_op('{rd_op, 3'h3, 3'h0, 8'h00}, 9'h180);
        // Wake disabled: an eligible pin change must not wake
        do_op('{cfg_op, 3'h0, 3'h0, 8'h80}, 9'h000);
        sleep = 1'b1;
        ext_b = 6'h2f;
        repeat (4) @(posedge clock);
        #1;
        `CHK(wake_reset, 1'b0)
        complete_run();
    end
endmodule

`default_nettype wire
